// >>> shared/daap_pkg.sv
package daap_pkg;

    // access point select value that routes the debug port here
    localparam logic [7:0]  AP_SEL_AUTH     = 8'hFF;

    // register offsets
    localparam logic [7:0]  OFF_CMD         = 8'h00;
    localparam logic [7:0]  OFF_KEY         = 8'h04;
    localparam logic [7:0]  OFF_STATUS      = 8'h08;
    localparam logic [7:0]  OFF_CTRL        = 8'h0C;
    localparam logic [7:0]  OFF_CRCCMD      = 8'h10;
    localparam logic [7:0]  OFF_CRCSTAT     = 8'h14;
    localparam logic [7:0]  OFF_PAGE_CRC_ADDRESS_FIELD     = 8'h18;
    localparam logic [7:0]  OFF_CRCRES      = 8'h1C;
    localparam logic [7:0]  OFF_IDR         = 8'hFC;

    // field positions
    localparam int          CMD_ERASE_BIT   = 0;
    localparam int          CMD_RESET_BIT   = 1;
    localparam int          STAT_ERASE_BIT  = 0;
    localparam int          STAT_LOCK_BIT   = 1;
    localparam int          CTRL_STALL_BIT  = 0;
    localparam int          CRCCMD_REQ_BIT  = 0;
    localparam int          CRCSTAT_BSY_BIT = 0;

    localparam logic [31:0] UNLOCK_KEY      = 32'hCFACC118;
    localparam logic [3:0]  ALW_OPEN        = 4'hF;
    // arbitrary value, not any real part's code
    localparam logic [31:0] IDENT_DEFAULT   = 32'h0A5A0001;
    localparam logic [5:0]  CRC_WIDTH       = 6'h20;

    // flash page map, 2 KB pages
    localparam logic [31:0] PAGE_MASK       = 32'hFFFFF800;
    localparam logic [31:0] MAIN_END        = 32'h00040000;
    localparam logic [31:0] UD_PAGE         = 32'h0FE00000;
    localparam logic [31:0] LB_PAGE         = 32'h0FE04000;
    localparam logic [31:0] WORD_ZERO       = 32'h00000000;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b01,
        LK_WAIT = 2'b10
    } daap_link_state_t;

    typedef struct packed {
        logic [7:0]  sel;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } daap_ap_req_t;

    typedef struct packed {
        daap_link_state_t state;
        logic             req_tgl;
        logic             ack_s1;
        logic             ack_s2;
        logic             ack_seen;
        logic             wr;
        logic [7:0]       addr;
        logic [31:0]      wdata;
        logic [31:0]      rdata;
        logic             done;
    } daap_link_regs_t;

    typedef struct packed {
        logic        req_s1;
        logic        req_s2;
        logic        req_seen;
        logic        ack_tgl;
        logic [31:0] rdata;
        logic        key_en;
        logic        bus_stall;
        logic        core_stall;
        logic        erase_busy;
        logic        crc_busy;
        logic [31:0] crc_addr;
        logic [31:0] crc_result;
        logic        locked;
        logic        rd_effect;
        logic        sys_rst_p;
        logic        erase_p;
        logic        crc_p;
    } daap_core_regs_t;

endpackage : daap_pkg

// >>> hdl/daap_auth_access_point.sv
`timescale 1ns/1ns
`default_nettype none

module daap_auth_access_point #(
    parameter logic [31:0] IDENT = daap_pkg::IDENT_DEFAULT
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  link_clk,
    input  wire logic                  ap_valid,
    input  wire daap_pkg::daap_ap_req_t ap_req,
    output logic                       ap_ready,
    output logic                       ap_done,
    output logic [31:0]                ap_rdata,
    input  wire logic                  rst_level_full,
    input  wire logic [3:0]            ap_lock_word,
    input  wire logic                  debug_lock_word_cleared,
    input  wire logic                  master_type_core,
    input  wire logic                  erase_done,
    input  wire logic                  crc_done,
    input  wire logic [31:0]           crc_value,
    output logic                       sys_reset_req,
    output logic                       erase_start,
    output logic                       crc_start,
    output logic [31:0]                crc_page_addr,
    output logic [5:0]                 crc_width,
    output logic                       bus_stall,
    output logic                       core_stall,
    output logic                       core_path_block,
    output logic                       flash_change_block,
    output logic                       ap_locked,
    output logic                       read_side_effect_en
);

    function automatic logic is_crc_page(input logic [31:0] a);
        logic [31:0] pg;
        pg = a & daap_pkg::PAGE_MASK;
        is_crc_page = (pg < daap_pkg::MAIN_END) ||
                      (pg == daap_pkg::UD_PAGE) ||
                      (pg == daap_pkg::LB_PAGE);
    endfunction : is_crc_page

    // ---------------- link domain ----------------
    daap_pkg::daap_link_regs_t lk_q;
    daap_pkg::daap_link_regs_t lk_d;
    daap_pkg::daap_core_regs_t co_q;
    daap_pkg::daap_core_regs_t co_d;

    logic lk_take;

    always_comb begin
        lk_d    = lk_q;
        lk_take = 1'b0;
        lk_d.done   = 1'b0;
        lk_d.ack_s1 = co_q.ack_tgl;
        lk_d.ack_s2 = lk_q.ack_s1;
        case (lk_q.state)
            daap_pkg::LK_IDLE: begin
                // other access ports are not ours; left to their owners
                if (ap_valid && ap_req.sel == daap_pkg::AP_SEL_AUTH) begin
                    lk_take      = 1'b1;
                    lk_d.wr      = ap_req.write;
                    lk_d.addr    = ap_req.addr;
                    lk_d.wdata   = ap_req.wdata;
                    lk_d.req_tgl = ~lk_q.req_tgl;
                    lk_d.state   = daap_pkg::LK_WAIT;
                end
            end
            daap_pkg::LK_WAIT: begin
                // core holds its read word until the next request
                if (lk_q.ack_s2 != lk_q.ack_seen) begin
                    lk_d.ack_seen = lk_q.ack_s2;
                    lk_d.rdata    = co_q.rdata;
                    lk_d.done     = 1'b1;
                    lk_d.state    = daap_pkg::LK_IDLE;
                end
            end
            default: begin
                lk_d.state = daap_pkg::LK_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            lk_q       <= '0;
            lk_q.state <= daap_pkg::LK_IDLE;
        end else begin
            lk_q <= lk_d;
        end
    end

    assign ap_ready = (lk_q.state == daap_pkg::LK_IDLE);
    assign ap_done  = lk_q.done;
    assign ap_rdata = lk_q.rdata;

    // ---------------- core domain ----------------
    logic        co_go;
    logic        co_wr;
    logic [31:0] rd_word;

    always_comb begin
        co_d   = co_q;
        co_d.req_s1    = lk_q.req_tgl;
        co_d.req_s2    = co_q.req_s1;
        co_d.sys_rst_p = 1'b0;
        co_d.erase_p   = 1'b0;
        co_d.crc_p     = 1'b0;
        co_d.locked    = (ap_lock_word != daap_pkg::ALW_OPEN);
        co_d.rd_effect = master_type_core;
        // addr and wdata are stable while the toggle is in flight
        co_go   = (co_q.req_s2 != co_q.req_seen);
        co_wr   = co_go && lk_q.wr;
        rd_word = daap_pkg::WORD_ZERO;

        if (co_q.erase_busy && erase_done) begin
            co_d.erase_busy = 1'b0;
        end
        if (co_q.crc_busy && crc_done) begin
            co_d.crc_busy   = 1'b0;
            co_d.crc_result = crc_value;
        end

        // reads never act on state, so no read side effects here
        if (lk_q.addr == daap_pkg::OFF_STATUS) begin
            rd_word[daap_pkg::STAT_ERASE_BIT] = co_q.erase_busy;
            rd_word[daap_pkg::STAT_LOCK_BIT]  = co_q.locked;
        end else if (lk_q.addr == daap_pkg::OFF_CTRL) begin
            rd_word[daap_pkg::CTRL_STALL_BIT] = co_q.bus_stall;
        end else if (lk_q.addr == daap_pkg::OFF_CRCSTAT) begin
            rd_word[daap_pkg::CRCSTAT_BSY_BIT] = co_q.crc_busy;
        end else if (lk_q.addr == daap_pkg::OFF_PAGE_CRC_ADDRESS_FIELD) begin
            rd_word = co_q.crc_addr;
        end else if (lk_q.addr == daap_pkg::OFF_CRCRES) begin
            rd_word = co_q.crc_result;
        end else if (lk_q.addr == daap_pkg::OFF_IDR) begin
            rd_word = IDENT;
        end else begin
            rd_word = daap_pkg::WORD_ZERO;
        end

        if (co_go) begin
            co_d.req_seen = co_q.req_s2;
            co_d.ack_tgl  = ~co_q.ack_tgl;
            co_d.rdata    = lk_q.wr ? daap_pkg::WORD_ZERO : rd_word;
        end

        if (co_wr) begin
            if (lk_q.addr == daap_pkg::OFF_KEY) begin
                // any other value withdraws the enable
                co_d.key_en = (lk_q.wdata == daap_pkg::UNLOCK_KEY);
            end else if (lk_q.addr == daap_pkg::OFF_CTRL) begin
                co_d.bus_stall = lk_q.wdata[daap_pkg::CTRL_STALL_BIT];
            end else if (lk_q.addr == daap_pkg::OFF_PAGE_CRC_ADDRESS_FIELD) begin
                co_d.crc_addr = lk_q.wdata;
            end else if (lk_q.addr == daap_pkg::OFF_CRCCMD) begin
                // busy or off-map requests are dropped silently
                if (lk_q.wdata[daap_pkg::CRCCMD_REQ_BIT] && !co_q.crc_busy &&
                    is_crc_page(co_q.crc_addr)) begin
                    co_d.crc_p      = 1'b1;
                    co_d.crc_busy   = 1'b1;
                    co_d.core_stall = 1'b1;
                end
            end else if (lk_q.addr == daap_pkg::OFF_CMD && co_q.key_en) begin
                if (lk_q.wdata[daap_pkg::CMD_RESET_BIT]) begin
                    if (rst_level_full) begin
                        // whole space back to reset, handshake kept
                        co_d.key_en     = 1'b0;
                        co_d.bus_stall  = 1'b0;
                        co_d.erase_busy = 1'b0;
                        co_d.crc_busy   = 1'b0;
                        co_d.crc_addr   = daap_pkg::WORD_ZERO;
                        co_d.crc_result = daap_pkg::WORD_ZERO;
                    end
                    co_d.sys_rst_p  = 1'b1;
                    co_d.core_stall = 1'b0;
                end else if (lk_q.wdata[daap_pkg::CMD_ERASE_BIT] &&
                             !co_q.locked && !co_q.erase_busy) begin
                    co_d.erase_p    = 1'b1;
                    co_d.erase_busy = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            co_q <= '0;
        end else begin
            co_q <= co_d;
        end
    end

    assign sys_reset_req       = co_q.sys_rst_p;
    // flash side wipes main block, SRAM, lock page incl. user lock
    assign erase_start         = co_q.erase_p;
    assign crc_start           = co_q.crc_p;
    assign crc_page_addr       = co_q.crc_addr;
    assign crc_width           = daap_pkg::CRC_WIDTH;
    assign bus_stall           = co_q.bus_stall;
    assign core_stall          = co_q.core_stall;
    assign core_path_block     = debug_lock_word_cleared;
    assign flash_change_block  = co_q.locked;
    assign ap_locked           = co_q.locked;
    assign read_side_effect_en = co_q.rd_effect;

    // ---------------- checks ----------------
    localparam int ANS_MIN = 3;
    localparam int ANS_MAX = 8;

    logic cmd_wr;
    logic crc_wr;
    logic ctrl_wr;
    assign cmd_wr  = co_wr && lk_q.addr == daap_pkg::OFF_CMD;
    assign crc_wr  = co_wr && lk_q.addr == daap_pkg::OFF_CRCCMD;
    assign ctrl_wr = co_wr && lk_q.addr == daap_pkg::OFF_CTRL;

    sequence s_take;
        ap_valid && ap_ready && ap_req.sel == daap_pkg::AP_SEL_AUTH;
    endsequence
    sequence s_answer;
        ##[ANS_MIN:ANS_MAX] ap_done;
    endsequence

    a_link_answer: assert property (@(posedge link_clk) disable iff (!nrst)
        s_take |-> s_answer)
        else $error("access point request not answered");
    a_key_gate: assert property (@(posedge clk) disable iff (!nrst)
        cmd_wr && !co_q.key_en |=> !sys_reset_req && !erase_start)
        else $error("command acted without key");
    a_crc_start: assert property (@(posedge clk) disable iff (!nrst)
        crc_start |-> co_q.crc_busy && core_stall && is_crc_page(crc_page_addr))
        else $error("crc start without busy, stall or valid page");
    a_crc_ignore: assert property (@(posedge clk) disable iff (!nrst)
        crc_wr && co_q.crc_busy |=> !crc_start)
        else $error("crc request taken while busy");
    a_crc_result: assert property (@(posedge clk) disable iff (!nrst)
        co_q.crc_busy && crc_done |=>
            !co_q.crc_busy && co_q.crc_result == $past(crc_value))
        else $error("crc result not captured");
    a_stall_core: assert property (@(posedge clk) disable iff (!nrst)
        $fell(core_stall) |-> sys_reset_req)
        else $error("core stall released without reset");
    a_lock_status: assert property (@(posedge clk) disable iff (!nrst)
        ##1 ap_locked == ($past(ap_lock_word) != daap_pkg::ALW_OPEN))
        else $error("lock status wrong");
    a_erase_gate: assert property (@(posedge clk) disable iff (!nrst)
        erase_start |-> !$past(ap_locked) && co_q.erase_busy)
        else $error("erase started while locked or not busy");
    a_stall_hold: assert property (@(posedge clk) disable iff (!nrst)
        bus_stall && !ctrl_wr && !cmd_wr |=> bus_stall)
        else $error("bus stall dropped by itself");
    a_reset_level: assert property (@(posedge clk) disable iff (!nrst)
        sys_reset_req |-> !($past(rst_level_full) && bus_stall))
        else $error("full reset left bus stall set");

    // link handshake shape
    a_ready_idle: assert property (@(posedge link_clk) disable iff (!nrst)
        ap_done |-> ap_ready)
        else $error("answer given while link busy");

    a_done_pulse: assert property (@(posedge link_clk) disable iff (!nrst)
        ap_done |=> !ap_done)
        else $error("answer longer than one cycle");

    // request words must not move while the core may read them
    a_req_steady: assert property (@(posedge link_clk) disable iff (!nrst)
        !ap_ready |=> $stable(lk_q.addr) && $stable(lk_q.wdata))
        else $error("request changed in flight");

    // command pulses, busy and stall holds, key, lock and read word checks
    a_reset_pulse: assert property (@(posedge clk) disable iff (!nrst)
        sys_reset_req |=> !sys_reset_req)
        else $error("reset request longer than one cycle");

    a_erase_pulse: assert property (@(posedge clk) disable iff (!nrst)
        erase_start |=> !erase_start)
        else $error("erase start longer than one cycle");

    a_crc_pulse: assert property (@(posedge clk) disable iff (!nrst)
        crc_start |=> !crc_start)
        else $error("crc start longer than one cycle");

    a_reset_go: assert property (@(posedge clk) disable iff (!nrst)
        cmd_wr && co_q.key_en && lk_q.wdata[daap_pkg::CMD_RESET_BIT] |=>
            sys_reset_req)
        else $error("keyed reset request lost");

    sequence s_erase_go;
        cmd_wr && co_q.key_en && lk_q.wdata[daap_pkg::CMD_ERASE_BIT] &&
            !lk_q.wdata[daap_pkg::CMD_RESET_BIT] && !co_q.locked &&
            !co_q.erase_busy;
    endsequence
    sequence s_erase_launch;
        ##1 erase_start && co_q.erase_busy;
    endsequence

    a_erase_launch: assert property (@(posedge clk) disable iff (!nrst)
        s_erase_go |-> s_erase_launch)
        else $error("keyed erase lost");

    a_erase_locked: assert property (@(posedge clk) disable iff (!nrst)
        cmd_wr && co_q.locked |=> !erase_start)
        else $error("erase started on locked part");

    a_erase_clear: assert property (@(posedge clk) disable iff (!nrst)
        co_q.erase_busy && erase_done |=> !co_q.erase_busy)
        else $error("erase busy kept after done");

    a_erase_hold: assert property (@(posedge clk) disable iff (!nrst)
        co_q.erase_busy && !erase_done && !cmd_wr |=> co_q.erase_busy)
        else $error("erase busy dropped early");

    sequence s_crc_go;
        crc_wr && lk_q.wdata[daap_pkg::CRCCMD_REQ_BIT] && !co_q.crc_busy &&
            is_crc_page(co_q.crc_addr);
    endsequence
    sequence s_crc_launch;
        ##1 crc_start && core_stall;
    endsequence

    a_crc_launch: assert property (@(posedge clk) disable iff (!nrst)
        s_crc_go |-> s_crc_launch)
        else $error("valid crc request lost");

    a_crc_offmap: assert property (@(posedge clk) disable iff (!nrst)
        crc_wr && !is_crc_page(co_q.crc_addr) |=> !crc_start)
        else $error("crc started on a page outside the map");

    a_crc_hold: assert property (@(posedge clk) disable iff (!nrst)
        co_q.crc_busy && !crc_done && !cmd_wr |=> co_q.crc_busy)
        else $error("crc busy dropped early");

    a_core_hold: assert property (@(posedge clk) disable iff (!nrst)
        core_stall && !cmd_wr |=> core_stall)
        else $error("core stall dropped without reset");

    a_stall_write: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_wr |=> bus_stall == $past(lk_q.wdata[daap_pkg::CTRL_STALL_BIT]))
        else $error("stall bit write not applied");

    a_key_hold: assert property (@(posedge clk) disable iff (!nrst)
        !(co_wr && lk_q.addr == daap_pkg::OFF_KEY) && !cmd_wr |=>
            $stable(co_q.key_en))
        else $error("key enable changed by itself");

    a_lock_paths: assert property (@(posedge clk) disable iff (!nrst)
        core_path_block == debug_lock_word_cleared &&
            flash_change_block == ap_locked)
        else $error("lock outputs disagree");

    a_side_effect: assert property (@(posedge clk) disable iff (!nrst)
        ##1 read_side_effect_en == $past(master_type_core))
        else $error("read side effect enable wrong");

    a_write_word: assert property (@(posedge clk) disable iff (!nrst)
        co_go && lk_q.wr |=> co_q.rdata == daap_pkg::WORD_ZERO)
        else $error("write answered with nonzero word");

    a_ctrl_read: assert property (@(posedge clk) disable iff (!nrst)
        co_go && !lk_q.wr && lk_q.addr == daap_pkg::OFF_CTRL |=>
            co_q.rdata[31:1] == 31'h0)
        else $error("reserved control bits read nonzero");

endmodule : daap_auth_access_point

`default_nettype wire

// >>> tb/daap_debugger_model.sv
`timescale 1ns/1ns
`default_nettype none
module daap_debugger_model (
    input  wire logic              link_clk,
    input  wire logic              ap_ready,
    input  wire logic              ap_done,
    input  wire logic [31:0]       ap_rdata,
    output logic                   ap_valid,
    output daap_pkg::daap_ap_req_t ap_req
);
    initial begin
        ap_valid = 1'b0;
        ap_req = '0;
    end
    // pre idle cycles make a slow debugger
    task automatic xfer(input logic [7:0] sel, input logic wr,
        input logic [7:0] a, input logic [31:0] d, input int pre,
        output logic [31:0] rd, output logic got);
        got = 1'b0;
        rd = '0;
        repeat (pre + 1) @(posedge link_clk);
        #1;
        ap_req = '{sel, wr, a, d};
        ap_valid = 1'b1;
        do @(posedge link_clk); while (ap_ready !== 1'b1);
        #1;
        ap_valid = 1'b0;
        // released lines must not look like the last request
        ap_req = ~ap_req;
        for (int n = 0; n < 12 && !got; n++) begin
            @(posedge link_clk);
            #1;
            got = ap_done;
            rd = ap_rdata;
        end
    endtask : xfer
endmodule : daap_debugger_model
`default_nettype wire

// >>> tb/daap_auth_access_point_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module daap_auth_access_point_tb_top;
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
    } daap_row_t;
    localparam logic [31:0] KEY = daap_pkg::UNLOCK_KEY;
    logic clk = 1'b0, link_clk = 1'b0, nrst = 1'b0;
    logic ap_valid, ap_ready, ap_done, got;
    daap_pkg::daap_ap_req_t ap_req;
    logic [31:0] ap_rdata, crc_value, crc_page_addr, rd;
    logic rst_level_full = 1'b0, debug_lock_word_cleared = 1'b0;
    logic master_type_core = 1'b0, erase_done = 1'b0, crc_done = 1'b0;
    logic [3:0] ap_lock_word = 4'hF;
    logic sys_reset_req, erase_start, crc_start, bus_stall, core_stall;
    logic core_path_block, flash_change_block, ap_locked;
    logic read_side_effect_en;
    logic [5:0] crc_width;
    logic [4:0] ok = 5'b10101;
    logic [31:0] pages [5] = '{32'h0003F804, 32'h00040000,
        32'h0FE00010, 32'h0FE00800, 32'h0FE047FC};
    int n_mismatch = 0, checked = 0, n_rst = 0, n_era = 0, n_crc = 0;
    int crc_cnt = 0, era_cnt = 0, pace = 0, c0;
    daap_row_t rows [20] = '{
        '{1'b0, 8'hFC, daap_pkg::IDENT_DEFAULT}, '{1'b0, 8'h00, 32'h0},
        '{1'b0, 8'h04, 32'h0}, '{1'b0, 8'h08, 32'h0},
        '{1'b0, 8'h0C, 32'h0}, '{1'b0, 8'h14, 32'h0},
        '{1'b0, 8'h18, 32'h0}, '{1'b0, 8'h1C, 32'h0},
        '{1'b0, 8'h20, 32'h0}, '{1'b1, 8'h0C, 32'hFFFFFFFF},
        '{1'b0, 8'h0C, 32'h1}, '{1'b1, 8'h0C, 32'h0},
        '{1'b1, 8'h18, 32'h0003F804}, '{1'b0, 8'h18, 32'h0003F804},
        '{1'b1, 8'h1C, 32'hFFFFFFFF}, '{1'b0, 8'h1C, 32'h0},
        '{1'b1, 8'h08, 32'hFFFFFFFF}, '{1'b0, 8'h08, 32'h0},
        '{1'b1, 8'h14, 32'hFFFFFFFF}, '{1'b0, 8'h14, 32'h0}};

    always #5 clk = ~clk;
    always #16 link_clk = ~link_clk;

    // flash and crc engine stand-ins, slow enough to be polled busy
    always @(posedge clk) begin
        n_rst <= n_rst + (sys_reset_req === 1'b1);
        n_era <= n_era + (erase_start === 1'b1);
        n_crc <= n_crc + (crc_start === 1'b1);
        crc_cnt <= crc_start ? 80 : crc_cnt - (crc_cnt > 0);
        era_cnt <= erase_start ? 80 : era_cnt - (era_cnt > 0);
        crc_done <= #1 (crc_cnt == 1);
        erase_done <= #1 (era_cnt == 1);
    end
    assign crc_value = crc_page_addr ^ 32'h5A5A0000;

    daap_auth_access_point DUT (.clk, .nrst, .link_clk, .ap_valid,
        .ap_req, .ap_ready, .ap_done, .ap_rdata, .rst_level_full,
        .ap_lock_word, .debug_lock_word_cleared, .master_type_core,
        .erase_done, .crc_done, .crc_value, .sys_reset_req,
        .erase_start, .crc_start, .crc_page_addr, .crc_width, .bus_stall,
        .core_stall, .core_path_block, .flash_change_block, .ap_locked,
        .read_side_effect_en);
    daap_debugger_model dbg (.link_clk, .ap_ready, .ap_done, .ap_rdata,
        .ap_valid, .ap_req);

    task automatic chk(input logic [31:0] g, e, input string m);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t %s: got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        dbg.xfer(8'hFF, 1'b1, a, d, pace, rd, got);
        chk({31'h0, got}, 32'h1, "write answered");
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
        input string m);
        dbg.xfer(8'hFF, 1'b0, a, '0, pace, rd, got);
        chk(rd, e, m);
        chk({31'h0, got}, 32'h1, m);
    endtask : rdc
    task automatic cmd(input logic [31:0] k, c);
        wr(8'h04, k);
        wr(8'h00, c);
    endtask : cmd
    task automatic poll(input logic [7:0] a);
        for (int n = 0; n < 30; n++) begin
            dbg.xfer(8'hFF, 1'b0, a, '0, 0, rd, got);
            if (rd[0] === 1'b0)
                break;
        end
        chk(rd, 32'h0, "busy falls");
    endtask : poll
    task automatic settle;
        @(posedge clk);
        #1;
    endtask : settle
    task automatic complete_run;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        repeat (8) @(posedge clk);
        chk({ap_ready, ap_done, bus_stall, core_stall}, 32'h8, "in reset");
        #1 nrst = 1'b1;
        repeat (3) @(posedge link_clk);
        foreach (rows[i]) begin
            if (rows[i].wr)
                wr(rows[i].a, rows[i].d);
            else
                rdc(rows[i].a, rows[i].d, "table");
        end
        $display("test registers done");
        pace = 2;
        wr(8'h0C, 32'h1);
        repeat (50) @(posedge clk);
        chk(bus_stall, 1'b1, "stall holds");
        wr(8'h0C, 32'h0);
        chk(bus_stall, 1'b0, "stall cleared");
        dbg.xfer(8'h00, 1'b1, 8'h0C, 32'h1, 0, rd, got);
        chk({got, bus_stall}, 32'h0, "other port");
        pace = 0;
        $display("test stall done");
        cmd(32'h0, 32'h2);
        cmd(KEY ^ 32'h1, 32'h1);
        cmd(KEY, 32'h0);
        chk(n_rst + n_era, 0, "no key or no one");
        cmd(KEY, 32'h2);
        chk(n_rst, 1, "reset request");
        settle();
        debug_lock_word_cleared = 1'b1;
        ap_lock_word = 4'h7;
        master_type_core = 1'b1;
        settle();
        chk({core_path_block, ap_locked, flash_change_block,
             read_side_effect_en}, 32'hF, "lock levels");
        rdc(8'h08, 32'h2, "locked status");
        cmd(KEY, 32'h1);
        chk(n_era, 0, "erase when locked");
        settle();
        ap_lock_word = 4'hF;
        master_type_core = 1'b0;
        settle();
        chk({ap_locked, read_side_effect_en}, 32'h0, "unlocked");
        cmd(KEY, 32'h1);
        chk(n_era, 1, "erase");
        rdc(8'h08, 32'h1, "erase busy");
        poll(8'h08);
        cmd(KEY, 32'h2);
        $display("test key erase lock done");
        wr(8'h0C, 32'h1);
        foreach (pages[i]) begin
            c0 = n_crc;
            wr(8'h18, pages[i]);
            wr(8'h10, 32'h1);
            chk(n_crc - c0, ok[i], "crc page");
            if (ok[i]) begin
                rdc(8'h14, 32'h1, "crc busy");
                wr(8'h10, 32'h1);
                chk(n_crc - c0, 1, "busy request");
                poll(8'h14);
                rdc(8'h1C, pages[i] ^ 32'h5A5A0000, "result");
                chk({core_stall, crc_width}, 32'h60, "crc mode");
            end
        end
        $display("test crc done");
        cmd(KEY, 32'h2);
        chk({core_stall, bus_stall}, 32'h1, "partial reset");
        rdc(8'h18, 32'h0FE047FC, "addr kept");
        rst_level_full = 1'b1;
        cmd(KEY, 32'h2);
        rdc(8'h0C, 32'h0, "full reset ctrl");
        rdc(8'h18, 32'h0, "full reset addr");
        wr(8'h00, 32'h2);
        chk(n_rst, 4, "key gone");
        $display("test reset levels done");
        // recovery: stall issued under reset, no answer expected
        @(posedge clk);
        #1 nrst = 1'b0;
        dbg.xfer(8'hFF, 1'b1, 8'h0C, 32'h1, 0, rd, got);
        chk(bus_stall, 1'b0, "stall in reset");
        @(posedge clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge link_clk);
        wr(8'h0C, 32'h1);
        chk(bus_stall, 1'b1, "stall after recovery");
        rdc(8'h18, 32'h0, "addr after reset");
        $display("test recovery done");
        complete_run();
    end

    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule : daap_auth_access_point_tb_top
`default_nettype wire
